// ### include/asci_defines.vh
`ifndef ASCI_DEFINES_VH
`define ASCI_DEFINES_VH

// register addresses
`define ASCI_ADDR_HSYNC_CFG   8'h0F
`define ASCI_ADDR_CTRL        8'h10
`define ASCI_ADDR_CLAMP_DLY   8'h11
`define ASCI_ADDR_CLAMP_LEN   8'h12
`define ASCI_ADDR_PPL_LO      8'h13
`define ASCI_ADDR_PPL_HI      8'h14
`define ASCI_ADDR_PHASE       8'h15
`define ASCI_ADDR_STATUS      8'h16
`define ASCI_ADDR_PERIOD_LO   8'h17
`define ASCI_ADDR_PERIOD_HI   8'h18

// field positions
`define ASCI_BIT_HSYNC_POL    7
`define ASCI_BIT_EXT_CLAMP_EN 7
`define ASCI_BIT_CLAMP_POL    6
`define ASCI_BIT_COAST_POL    5
`define ASCI_BIT_EXT_CLK_SEL  4
`define ASCI_BIT_INT_COAST_EN 3

// reset values
`define ASCI_RST_HSYNC_CFG    8'h00
`define ASCI_RST_CTRL         8'h20
`define ASCI_RST_CLAMP_DLY    8'h08
`define ASCI_RST_CLAMP_LEN    8'h10
`define ASCI_RST_PPL          12'h320
`define ASCI_RST_PHASE        5'h00

// timing: internal coast fires when a line runs this much past the measured period
`define ASCI_COAST_MARGIN_NS  200
`define ASCI_CLK_PERIOD_NS    4
`define ASCI_COAST_MARGIN_CYC (`ASCI_COAST_MARGIN_NS / `ASCI_CLK_PERIOD_NS)

`endif

// ### rtl/asci_sync_clock_ctrl.v
// Summary of operation
// - hsync polarity comes from register 0Fh bit 7.
// - polarity 0 makes the falling hsync edge active, 1 the rising edge.
// - only the leading hsync edge references pixel clock timing; trailing edge ignored.
// - external clamp pin honoured only when enable bit is 1; enable resets 0.
// - clamp disabled: pin ignored, window counted as delay then duration from trailing edge.
// - external clamp active level follows the clamp polarity setting.
// - during coast the generator stops tracking hsync, keeps frequency and phase.
// - coast input active level follows coast polarity bit, which resets to 1.
// - an internally generated coast from sync processing is offered as alternative.
// - external clock select 1 uses the external clock instead of generated clock.
// - with external clock everything else works, including phase adjustment.
// - sliced green sync output is a noninverting copy of the embedded sync.
// - phase change moves data clock, sample strobe and aligned hsync together.
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "asci_defines.vh"

module asci_sync_clock_ctrl #(
	parameter PERIOD_W = 16,
	parameter PPL_W    = 12,
	parameter PHASE_W  = 5
) (
	input  wire       clk_sys,
	input  wire       rstn,
	input  wire [7:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_wr,
	input  wire       reg_rd,
	output reg  [7:0] reg_rdata,
	input  wire       hsync_in,
	input  wire       clamp_in,
	input  wire       coast_in,
	input  wire       external_pixel_clock_in,
	input  wire       green_embedded_sync_in,
	output reg        sliced_green_sync_out,
	output reg        clamp_active,
	output reg        sample_strobe,
	output reg        output_data_clock,
	output reg        aligned_hsync_out
);

	localparam DEPTH = 1 << PHASE_W;

	// two-stage synchronisers; stage one feeds stage two only
	reg [4:0] sync1_q;
	reg [4:0] sync2_q;
	reg       hs_act_q;
	reg       ext_clk_q;

	// registers
	reg [7:0]         hsync_cfg_q;
	reg [7:0]         ctrl_q;
	reg [7:0]         clamp_dly_q;
	reg [7:0]         clamp_len_q;
	reg [PPL_W-1:0]   ppl_q;
	reg [PHASE_W-1:0] phase_q;

	// line tracking
	reg [PERIOD_W-1:0] line_cnt_q;
	reg [PERIOD_W-1:0] period_q;
	reg [PERIOD_W-1:0] acc_q;
	reg                period_valid_q;
	reg                int_coast_q;

	// clamp window generator
	localparam CL_IDLE  = 3'b001;
	localparam CL_DELAY = 3'b010;
	localparam CL_HOLD  = 3'b100;
	reg [2:0] cl_state_q;
	reg [7:0] cl_cnt_q;

	// phase delay line, tick and hsync travel together
	reg [DEPTH-1:0] tick_dly_q;
	reg [DEPTH-1:0] hs_dly_q;

	wire hsync_s   = sync2_q[0];
	wire clamp_s   = sync2_q[1];
	wire coast_s   = sync2_q[2];
	wire ext_clk_s = sync2_q[3];
	wire green_s   = sync2_q[4];

	// conditional inversion, so everything downstream sees an active-high input
	function apply_pol;
		input level;
		input active_high;
		begin
			apply_pol = level ^ ~active_high;
		end
	endfunction

	wire hsync_pol     = hsync_cfg_q[`ASCI_BIT_HSYNC_POL];
	wire ext_clamp_en  = ctrl_q[`ASCI_BIT_EXT_CLAMP_EN];
	wire clamp_pol     = ctrl_q[`ASCI_BIT_CLAMP_POL];
	wire coast_pol     = ctrl_q[`ASCI_BIT_COAST_POL];
	wire ext_clk_sel   = ctrl_q[`ASCI_BIT_EXT_CLK_SEL];
	wire int_coast_en  = ctrl_q[`ASCI_BIT_INT_COAST_EN];

	// inverted before edge detection so the active edge is always a rise
	wire hs_act     = apply_pol(hsync_s, hsync_pol);
	wire hs_lead    = hs_act & ~hs_act_q;
	wire hs_trail   = ~hs_act & hs_act_q;
	wire clamp_ext  = apply_pol(clamp_s, clamp_pol);
	wire coast_ext  = apply_pol(coast_s, coast_pol);
	wire coast      = coast_ext | (int_coast_en & int_coast_q);

	wire [PERIOD_W:0] acc_sum = {1'b0, acc_q} + {{(PERIOD_W+1-PPL_W){1'b0}}, ppl_q};
	wire              acc_wrap = period_valid_q && (acc_sum >= {1'b0, period_q});
	wire              gen_tick = acc_wrap;
	// the external clock is sampled as data, so it must run below half the system clock
	wire              ext_tick = ext_clk_s & ~ext_clk_q;
	wire              pix_tick = ext_clk_sel ? ext_tick : gen_tick;

	// margin held at the counter's width; the sum saturates so a long line cannot wrap it
	localparam [PERIOD_W-1:0] COAST_MARGIN = `ASCI_COAST_MARGIN_CYC;
	wire [PERIOD_W:0]   coast_sum   = {1'b0, period_q} + {1'b0, COAST_MARGIN};
	wire [PERIOD_W-1:0] coast_limit =
		coast_sum[PERIOD_W] ? {PERIOD_W{1'b1}} : coast_sum[PERIOD_W-1:0];

	// status: coast, clamp window, hsync active level, period valid, internal coast
	wire [7:0] status_word = {coast, clamp_active, hs_act, period_valid_q, int_coast_q, 3'h0};

	function sel_reg;
		input [7:0] addr;
		input [7:0] target;
		begin
			sel_reg = (addr == target);
		end
	endfunction

	always @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			sync1_q   <= 5'h00;
			sync2_q   <= 5'h00;
			// equals hs_act under the reset polarity with a low pin, so no false edge follows
			hs_act_q  <= 1'b1;
			ext_clk_q <= 1'b0;
		end
		else
		begin
			sync1_q   <= {green_embedded_sync_in, external_pixel_clock_in, coast_in,
				clamp_in, hsync_in};
			sync2_q   <= sync1_q;
			hs_act_q  <= hs_act;
			ext_clk_q <= ext_clk_s;
		end
	end

	// register writes
	always @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			hsync_cfg_q <= `ASCI_RST_HSYNC_CFG;
			ctrl_q      <= `ASCI_RST_CTRL;
			clamp_dly_q <= `ASCI_RST_CLAMP_DLY;
			clamp_len_q <= `ASCI_RST_CLAMP_LEN;
			ppl_q       <= `ASCI_RST_PPL;
			phase_q     <= `ASCI_RST_PHASE;
		end
		else if (reg_wr)
		begin
			// status and period addresses are read-only and fall through untouched
			if (sel_reg(reg_addr, `ASCI_ADDR_HSYNC_CFG))
				hsync_cfg_q <= reg_wdata & 8'h80;
			if (sel_reg(reg_addr, `ASCI_ADDR_CTRL))
				ctrl_q <= reg_wdata & 8'hF8;
			if (sel_reg(reg_addr, `ASCI_ADDR_CLAMP_DLY))
				clamp_dly_q <= reg_wdata;
			if (sel_reg(reg_addr, `ASCI_ADDR_CLAMP_LEN))
				clamp_len_q <= reg_wdata;
			if (sel_reg(reg_addr, `ASCI_ADDR_PPL_LO))
				ppl_q[7:0] <= reg_wdata;
			if (sel_reg(reg_addr, `ASCI_ADDR_PPL_HI))
				ppl_q[PPL_W-1:8] <= reg_wdata[PPL_W-9:0];
			if (sel_reg(reg_addr, `ASCI_ADDR_PHASE))
				phase_q <= reg_wdata[PHASE_W-1:0];
		end
	end

	// register reads, data in the following cycle; unmapped reads return zero
	always @(posedge clk_sys)
	begin
		if (!rstn)
			reg_rdata <= 8'h00;
		else if (reg_rd)
		begin
			case (reg_addr)
				`ASCI_ADDR_HSYNC_CFG: reg_rdata <= hsync_cfg_q;
				`ASCI_ADDR_CTRL:      reg_rdata <= ctrl_q;
				`ASCI_ADDR_CLAMP_DLY: reg_rdata <= clamp_dly_q;
				`ASCI_ADDR_CLAMP_LEN: reg_rdata <= clamp_len_q;
				`ASCI_ADDR_PPL_LO:    reg_rdata <= ppl_q[7:0];
				`ASCI_ADDR_PPL_HI:    reg_rdata <= {{(16-PPL_W){1'b0}}, ppl_q[PPL_W-1:8]};
				`ASCI_ADDR_PHASE:     reg_rdata <= {{(8-PHASE_W){1'b0}}, phase_q};
				`ASCI_ADDR_STATUS:    reg_rdata <= status_word;
				`ASCI_ADDR_PERIOD_LO: reg_rdata <= period_q[7:0];
				`ASCI_ADDR_PERIOD_HI: reg_rdata <= period_q[15:8];
				default:              reg_rdata <= 8'h00;
			endcase
		end
		else
			reg_rdata <= 8'h00;
	end

	// line period measurement and generated pixel clock.
	// a single wrap per cycle limits the pixel rate to below the system clock.
	always @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			line_cnt_q     <= {PERIOD_W{1'b0}};
			period_q       <= {PERIOD_W{1'b0}};
			period_valid_q <= 1'b0;
			acc_q          <= {PERIOD_W{1'b0}};
			int_coast_q    <= 1'b0;
		end
		else
		begin
			if (hs_lead)
				line_cnt_q <= {PERIOD_W{1'b0}};
			else if (line_cnt_q != {PERIOD_W{1'b1}})
				line_cnt_q <= line_cnt_q + 1'b1;

			// missing leading edges raise the internal coast until sync returns
			if (hs_lead)
				int_coast_q <= 1'b0;
			else if (period_valid_q && line_cnt_q > coast_limit)
				int_coast_q <= 1'b1;

			// during coast frequency and phase are frozen: no re-measure, no re-align
			if (hs_lead && !coast)
			begin
				// a line no longer than the pixel count plus one cannot be real, so it is not measured
				if (line_cnt_q > {{(PERIOD_W-PPL_W){1'b0}}, ppl_q})
				begin
					period_q       <= line_cnt_q + 1'b1;
					period_valid_q <= 1'b1;
				end
				acc_q <= {PERIOD_W{1'b0}};
			end
			else if (acc_wrap)
				acc_q <= acc_sum[PERIOD_W-1:0] - period_q;
			else
				acc_q <= acc_sum[PERIOD_W-1:0];
		end
	end

	// internal clamp window counted from the trailing hsync edge
	always @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			cl_state_q <= CL_IDLE;
			cl_cnt_q   <= 8'h00;
		end
		else
		begin
			case (cl_state_q)
				CL_IDLE:
				begin
					// a zero delay opens the window at once, a zero length opens none
					if (hs_trail && clamp_dly_q != 8'h00)
					begin
						cl_cnt_q   <= clamp_dly_q;
						cl_state_q <= CL_DELAY;
					end
					else if (hs_trail && clamp_len_q != 8'h00)
					begin
						cl_cnt_q   <= clamp_len_q;
						cl_state_q <= CL_HOLD;
					end
				end
				CL_DELAY:
				begin
					if (cl_cnt_q <= 8'h01)
					begin
						cl_cnt_q   <= clamp_len_q;
						// a zero length closes the window before it opens
						cl_state_q <= (clamp_len_q == 8'h00) ? CL_IDLE : CL_HOLD;
					end
					else
						cl_cnt_q <= cl_cnt_q - 8'h01;
				end
				CL_HOLD:
				begin
					if (cl_cnt_q <= 8'h01)
						cl_state_q <= CL_IDLE;
					else
						cl_cnt_q <= cl_cnt_q - 8'h01;
				end
				default:
					cl_state_q <= CL_IDLE;
			endcase
		end
	end

	// phase adjustment applies to both clock sources, and moves tick and hsync alike
	// a phase change acts on the next clock and may drop or repeat every strobe that falls within the shift
	always @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			tick_dly_q <= {DEPTH{1'b0}};
			hs_dly_q   <= {DEPTH{1'b0}};
		end
		else
		begin
			tick_dly_q <= {tick_dly_q[DEPTH-2:0], pix_tick};
			hs_dly_q   <= {hs_dly_q[DEPTH-2:0], hs_act};
		end
	end

	always @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			sliced_green_sync_out <= 1'b0;
			clamp_active          <= 1'b0;
			sample_strobe         <= 1'b0;
			output_data_clock     <= 1'b0;
			aligned_hsync_out     <= 1'b0;
		end
		else
		begin
			sliced_green_sync_out <= green_s;
			// ext clamp enabled: pin only; disabled: pin ignored
			clamp_active <= ext_clamp_en ? clamp_ext
				: (cl_state_q == CL_HOLD);
			sample_strobe     <= tick_dly_q[phase_q];
			aligned_hsync_out <= hs_dly_q[phase_q];
			// data clock is a divided strobe, so it runs at half the pixel rate
			if (tick_dly_q[phase_q])
				output_data_clock <= ~output_data_clock;
		end
	end

endmodule

// ### verification/asci_src_model.sv
`timescale 1ns/1ps
module asci_src_model (
	input  wire        clk_sys,
	input  wire        run,
	input  wire        pol,
	input  wire [11:0] period,
	input  wire        use_clamp,
	input  wire        use_ext_clk,
	output reg         hsync_in,
	output reg         clamp_in,
	output reg         external_pixel_clock_in,
	output reg         green_embedded_sync_in
);
	reg [11:0] cnt_q = 12'h000;
	reg [1:0]  div_q = 2'h0;
	initial
	begin
		hsync_in = 1'b0;
		clamp_in = 1'b0;
		external_pixel_clock_in = 1'b0;
		green_embedded_sync_in = 1'b0;
	end
	always @(posedge clk_sys)
	begin
		cnt_q <= (!run || cnt_q == period - 12'h001) ? 12'h000 : cnt_q + 12'h001;
		div_q <= div_q + 2'h1;
		hsync_in <= (run && cnt_q < 12'h010) ? pol : ~pol;
		green_embedded_sync_in <= run && cnt_q < 12'h010;
		// clamp only in the back porch, held low when unused
		clamp_in <= use_clamp && run && cnt_q >= 12'h014 && cnt_q < 12'h01C;
		external_pixel_clock_in <= use_ext_clk & div_q[1];
	end
endmodule

// ### verification/asci_sync_clock_ctrl_props.sv
`timescale 1ns/1ps
module asci_sync_clock_ctrl_props (
	input wire       clk_sys,
	input wire       rstn,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire       reg_wr,
	input wire       reg_rd,
	input wire [7:0] reg_rdata,
	input wire       hsync_in,
	input wire       clamp_in,
	input wire       coast_in,
	input wire       external_pixel_clock_in,
	input wire       green_embedded_sync_in,
	input wire       sliced_green_sync_out,
	input wire       clamp_active,
	input wire       sample_strobe,
	input wire       output_data_clock,
	input wire       aligned_hsync_out
);
	reg [7:0] ctl_q;
	reg [7:0] len_q;
	reg [7:0] ph_q;
	reg [7:0] qt_q;
	reg [7:0] up_q;
	reg [7:0] hi_q;
	reg       pol_q;
	always @(posedge clk_sys)
	begin
		hi_q <= clamp_active ? hi_q + 8'h01 : 8'h00;
		up_q <= !rstn ? 8'h00 : up_q + {7'h00, up_q != 8'hFF};
		qt_q <= (!rstn || reg_wr) ? 8'h00 : qt_q + {7'h00, qt_q != 8'hFF};
		if (!rstn)
		begin
			ctl_q <= 8'h20;
			pol_q <= 1'b0;
			len_q <= 8'h10;
			ph_q <= 8'h00;
		end
		else if (reg_wr)
		begin
			if (reg_addr == 8'h10) ctl_q <= reg_wdata & 8'hF8;
			if (reg_addr == 8'h0F) pol_q <= reg_wdata[7];
			if (reg_addr == 8'h12) len_q <= reg_wdata;
			if (reg_addr == 8'h15) ph_q <= reg_wdata;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	sequence s_tick;
		##[1:12] sample_strobe;
	endsequence
	property p_cfg_rd;
		up_q > 2 && $past(reg_rd) && $past(reg_addr) == 8'h0F |-> reg_rdata == {$past(pol_q), 7'h00};
	endproperty
	a_cfg_rd: assert property (p_cfg_rd) else $error("hsync config readback");
	property p_ctl_rd;
		up_q > 2 && $past(reg_rd) && $past(reg_addr) == 8'h10 |-> reg_rdata == $past(ctl_q);
	endproperty
	a_ctl_rd: assert property (p_ctl_rd) else $error("control readback");
	property p_green;
		up_q > 4 |-> sliced_green_sync_out == $past(green_embedded_sync_in, 3);
	endproperty
	a_green: assert property (p_green) else $error("sliced sync mismatch");
	property p_hs0;
		qt_q > 12 && ph_q == 0 |-> aligned_hsync_out == $past(hsync_in ~^ pol_q, 4);
	endproperty
	a_hs0: assert property (p_hs0) else $error("aligned hsync level");
	property p_hs3;
		qt_q > 12 && ph_q == 3 |-> aligned_hsync_out == $past(hsync_in ~^ pol_q, 7);
	endproperty
	a_hs3: assert property (p_hs3) else $error("aligned hsync phase");
	property p_xclamp;
		qt_q > 12 && ctl_q[7] |-> clamp_active == $past(clamp_in ~^ ctl_q[6], 3);
	endproperty
	a_xclamp: assert property (p_xclamp) else $error("external clamp level");
	property p_iclamp;
		qt_q == 8'hFF && !ctl_q[7] && $fell(clamp_active) |-> hi_q == len_q;
	endproperty
	a_iclamp: assert property (p_iclamp) else $error("internal clamp length");
	property p_xtick;
		qt_q > 12 && ctl_q[4] && ph_q < 5 && $rose(external_pixel_clock_in) |-> s_tick;
	endproperty
	a_xtick: assert property (p_xtick) else $error("no strobe for ext clock");
	property p_odc;
		up_q > 8 && $changed(output_data_clock) |-> sample_strobe || $past(sample_strobe);
	endproperty
	a_odc: assert property (p_odc) else $error("data clock toggle");
endmodule
bind asci_sync_clock_ctrl asci_sync_clock_ctrl_props u_props (.*);

// ### verification/asci_sync_clock_ctrl_tb.sv
`timescale 1ns/1ps
module asci_sync_clock_ctrl_tb;
	reg        clk_sys = 1'b0;
	reg        rstn = 1'b0;
	reg  [7:0] reg_addr = 8'h00;
	reg  [7:0] reg_wdata = 8'h00;
	reg        reg_wr = 1'b0;
	reg        reg_rd = 1'b0;
	reg        coast_in = 1'b0;
	reg        run = 1'b0;
	reg        pol = 1'b1;
	reg [11:0] period = 12'h0C8;
	reg        use_clamp = 1'b1;
	reg        use_ext_clk = 1'b0;
	wire [7:0] reg_rdata;
	wire       hsync_in, clamp_in, external_pixel_clock_in, green_embedded_sync_in;
	wire       sliced_green_sync_out, clamp_active, sample_strobe;
	wire       output_data_clock, aligned_hsync_out;
	integer    num_errors = 0;
	integer    checked = 0;
	asci_sync_clock_ctrl uut (.*);
	asci_src_model u_src (.*);
	always #2 clk_sys = ~clk_sys;
	task chk(input [15:0] got, input [15:0] exp);
	begin
		checked = checked + 1;
		if (got !== exp)
		begin
			num_errors = num_errors + 1;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask
	task wr(input [7:0] a, input [7:0] d);
	begin
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		@(posedge clk_sys);
	end
	endtask
	task rd(input [7:0] a, input [7:0] m, input [7:0] e);
	begin
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk({8'h00, reg_rdata & m}, {8'h00, e});
		@(posedge clk_sys);
	end
	endtask
	// counts over whole line or clock periods so the phase of the window does not matter
	task cnt(input sel, input integer len, input [15:0] e);
	integer c;
	begin
		c = 0;
		repeat (len)
		begin
			@(posedge clk_sys);
			#1 c = c + (sel ? sample_strobe : clamp_active);
		end
		chk(c[15:0], e);
	end
	endtask
	task print_verdict;
	begin
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	end
	endtask
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		num_errors = num_errors + 1;
		print_verdict;
	end
	initial
	begin
		repeat (6) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		rd(8'h0F, 8'hFF, 8'h00);
		rd(8'h10, 8'hFF, 8'h20);
		rd(8'h20, 8'hFF, 8'h00);
		$display("test 1 done");
		wr(8'h13, 8'h64);
		wr(8'h14, 8'h00);
		wr(8'h0F, 8'h80);
		run <= 1'b1;
		repeat (700) @(posedge clk_sys);
		rd(8'h17, 8'hFF, 8'hC8);
		rd(8'h18, 8'hFF, 8'h00);
		$display("test 2 done");
		wr(8'h11, 8'h03);
		wr(8'h12, 8'h04);
		repeat (300) @(posedge clk_sys);
		cnt(1'b0, 200, 16'h0004);
		$display("test 3 done");
		wr(8'h10, 8'hE0);
		repeat (20) @(posedge clk_sys);
		cnt(1'b0, 200, 16'h0008);
		wr(8'h10, 8'hA0);
		repeat (20) @(posedge clk_sys);
		cnt(1'b0, 200, 16'h00C0);
		wr(8'h10, 8'h20);
		$display("test 4 done");
		coast_in <= 1'b1;
		repeat (10) @(posedge clk_sys);
		rd(8'h16, 8'h80, 8'h80);
		period <= 12'h12C;
		repeat (900) @(posedge clk_sys);
		rd(8'h17, 8'hFF, 8'hC8);
		coast_in <= 1'b0;
		repeat (900) @(posedge clk_sys);
		rd(8'h17, 8'hFF, 8'h2C);
		wr(8'h10, 8'h00);
		rd(8'h16, 8'h80, 8'h80);
		coast_in <= 1'b1;
		repeat (10) @(posedge clk_sys);
		rd(8'h16, 8'h80, 8'h00);
		$display("test 5 done");
		wr(8'h10, 8'h28);
		coast_in <= 1'b0;
		run <= 1'b0;
		repeat (500) @(posedge clk_sys);
		rd(8'h16, 8'h08, 8'h08);
		run <= 1'b1;
		repeat (700) @(posedge clk_sys);
		rd(8'h16, 8'h08, 8'h00);
		$display("test 6 done");
		pol <= 1'b0;
		wr(8'h0F, 8'h00);
		use_ext_clk <= 1'b1;
		wr(8'h10, 8'h30);
		repeat (20) @(posedge clk_sys);
		cnt(1'b1, 400, 16'h0064);
		wr(8'h15, 8'h03);
		repeat (900) @(posedge clk_sys);
		cnt(1'b1, 400, 16'h0064);
		rd(8'h18, 8'hFF, 8'h01);
		$display("test 7 done");
		print_verdict;
	end
endmodule
